// >>> common/sled_pkg.sv
// Constants, register map and carrier types of the status LED error indicator
package sled_pkg;
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam longint unsigned CLK_KHZ = 64'd250_000;
	// Trigger stall time in seconds
	localparam longint unsigned STALL_TIME_S = 64'd5;
	localparam longint unsigned STALL_CYCLES_DEF = STALL_TIME_S * CLK_HZ;
	// Slow flash timing in milliseconds
	localparam longint unsigned FLASH_ON_MS = 64'd300;
	localparam longint unsigned FLASH_OFF_MS = 64'd300;
	localparam longint unsigned FLASH_GAP_MS = 64'd1500;
	localparam longint unsigned FLASH_ON_DEF = FLASH_ON_MS * CLK_KHZ;
	localparam longint unsigned FLASH_OFF_DEF = FLASH_OFF_MS * CLK_KHZ;
	localparam longint unsigned FLASH_GAP_DEF = FLASH_GAP_MS * CLK_KHZ;

	// Flash counts and their priority levels
	localparam logic [2:0] FLASH_SOLID = 3'h0;
	localparam logic [2:0] FLASH_CMD = 3'h4;
	localparam logic [2:0] FLASH_SHADE = 3'h3;
	localparam logic [2:0] FLASH_LINE = 3'h2;
	localparam logic [3:0] PRIO_CMD = 4'h7;
	localparam logic [3:0] PRIO_SHADE = 4'h8;
	localparam logic [3:0] PRIO_LINE = 4'h9;
	localparam logic [3:0] PRIO_NONE = 4'h0;

	// APB register byte offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CLEAR = 8'h04;
	localparam logic [7:0] OFS_ENABLE = 8'h08;
	localparam logic [7:0] OFS_COND = 8'h0C;
	localparam logic [7:0] OFS_CAUSE = 8'h10;
	localparam logic [7:0] OFS_CMDACK = 8'h14;
	localparam logic [7:0] OFS_CTRL = 8'h18;
	localparam logic [0:0] CTRL_RESET = 1'h1;

	// Event bit positions, shared by status, clear and enable
	localparam int EV_CMD = 0;
	localparam int EV_SHADE = 1;
	localparam int EV_RATE = 2;
	localparam int EV_STALL = 3;
	localparam int EV_W = 4;

	// Serial command parser error pulses
	typedef struct packed {
		logic unknownFmt;
		logic noFrameStart;
		logic badLength;
		logic badAddress;
		logic badCheckChar;
		logic badOpcode;
		logic byteTimeout;
	} sled_cmd_err_t;

	typedef struct packed {
		logic [31:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} sled_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} sled_apb_rsp_t;
endpackage

// >>> rtl/sled_flash_gen.sv
// Slow flash pattern generator for the status LED
`timescale 1ns/1ps
module sled_flash_gen #(
	parameter logic [31:0] ON_CYCLES = 32'h0000_0004,
	parameter logic [31:0] OFF_CYCLES = 32'h0000_0004,
	parameter logic [31:0] GAP_CYCLES = 32'h0000_0010
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Pattern request
	input wire logic [2:0] flashCount,
	// LED drive
	output logic ledOn
);
	import sled_pkg::*;

	typedef enum logic [1:0] {SOLID, LIT, DARK, GAP} sled_fstate_t;

	sled_fstate_t state_r;
	logic [31:0] timer_r;
	logic [2:0] done_r;
	logic [2:0] count_r;
	logic changed;

	// A new flashing pattern restarts with its gap, then its first flash; solid goes straight on
	assign changed = flashCount != count_r;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			count_r <= FLASH_SOLID;
		else
			count_r <= flashCount;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_r <= SOLID;
			timer_r <= 32'h0;
			done_r <= 3'h0;
		end
		else if (changed)
		begin
			state_r <= (flashCount == FLASH_SOLID) ? SOLID : GAP;
			timer_r <= 32'h0;
			done_r <= 3'h0;
		end
		else
		begin
			timer_r <= timer_r + 32'h1;
			case (state_r)
				SOLID:
					timer_r <= 32'h0;
				LIT:
					if (timer_r >= ON_CYCLES - 32'h1)
					begin
						state_r <= DARK;
						timer_r <= 32'h0;
						done_r <= done_r + 3'h1;
					end
				DARK:
					if (timer_r >= OFF_CYCLES - 32'h1)
					begin
						timer_r <= 32'h0;
						state_r <= (done_r == count_r) ? GAP : LIT;
					end
				GAP:
					if (timer_r >= GAP_CYCLES - 32'h1)
					begin
						state_r <= LIT;
						timer_r <= 32'h0;
						done_r <= 3'h0;
					end
				default:
					state_r <= SOLID;
			endcase
		end
	end

	assign ledOn = (state_r == SOLID) || (state_r == LIT);
endmodule

// >>> rtl/sled_error_indicator.sv
// Status LED error indicator with APB registers and interrupt
// Operation
// - Any serial command error shows four slow orange flashes, priority 7.
// - Bytes arriving outside a frame start are discarded and flagged.
// - A failed shading generation shows three slow flashes, priority 8.
// - Shading failure stays until a successful generation or reset.
// - Excess line rate shows two slow flashes, lowest priority 9.
// - Line trigger unchanged for five seconds also shows two flashes.
// - With nothing active the LED is solid orange.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module sled_error_indicator #(
	parameter logic [31:0] STALL_CYCLES =
		32'(sled_pkg::STALL_CYCLES_DEF),
	parameter logic [31:0] FLASH_ON = 32'(sled_pkg::FLASH_ON_DEF),
	parameter logic [31:0] FLASH_OFF = 32'(sled_pkg::FLASH_OFF_DEF),
	parameter logic [31:0] FLASH_GAP = 32'(sled_pkg::FLASH_GAP_DEF)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// APB slave
	input wire sled_pkg::sled_apb_req_t apbReq,
	output sled_pkg::sled_apb_rsp_t apbRsp,
	// Serial command parser
	input wire sled_pkg::sled_cmd_err_t cmdErr,
	input wire logic rxByteValid,
	input wire logic rxFrameOpen,
	output logic rxByteDiscard,
	// Shading unit
	input wire logic shadeDone,
	input wire logic shadeFail,
	// Line trigger logic and pin
	input wire logic lineRateExceeded,
	input wire logic external_line_trigger,
	// Status LED and interrupt
	output logic ledOrange,
	output logic irq
);
	import sled_pkg::*;

	logic [EV_W-1:0] status_r;
	logic [EV_W-1:0] enable_r;
	logic [6:0] cause_r;
	logic cmdCond_r;
	logic shadeCond_r;
	logic stallCond_r;
	logic [0:0] ctrl_r;
	logic trigMeta_r;
	logic trigSync_r;
	logic trigLast_r;
	logic [31:0] stallCnt_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic discard_r;
	logic led_r;
	logic irq_r;
	logic [2:0] flashSel_r;
	logic [3:0] prioSel_r;
	logic [2:0] flashNxt;
	logic [3:0] prioNxt;
	logic [EV_W-1:0] events;
	logic discardNow;
	logic [6:0] cmdPulses;
	logic access;
	logic wrEn;
	logic rdEn;
	logic ledRaw;
	logic [7:0] regOfs;

	function automatic logic known(input logic [7:0] ofs);
		known = (ofs == OFS_STATUS) || (ofs == OFS_CLEAR) ||
			(ofs == OFS_ENABLE) || (ofs == OFS_COND) ||
			(ofs == OFS_CAUSE) || (ofs == OFS_CMDACK) ||
			(ofs == OFS_CTRL);
	endfunction

	// Answer in the second access cycle; high address bits must be zero
	assign regOfs = apbReq.paddr[7:0];
	assign access = apbReq.psel && apbReq.penable && !pready_r;
	// Writes land only on the edge that completes the transfer
	assign wrEn = apbReq.psel && apbReq.penable && pready_r &&
		apbReq.pwrite && known(regOfs) && apbReq.paddr[31:8] == 24'h0;
	assign rdEn = access && !apbReq.pwrite;

	// Frame start missing on an incoming byte
	assign discardNow = rxByteValid && !rxFrameOpen;
	assign cmdPulses = cmdErr | {1'b0, discardNow, 5'h0};

	assign events[EV_CMD] = |cmdPulses;
	assign events[EV_SHADE] = shadeDone && shadeFail;
	assign events[EV_RATE] = lineRateExceeded;
	assign events[EV_STALL] = stallCond_r;

	// Pin synchroniser, then edge detection on the second stage
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			trigMeta_r <= 1'b0;
			trigSync_r <= 1'b0;
			trigLast_r <= 1'b0;
		end
		else
		begin
			trigMeta_r <= external_line_trigger;
			trigSync_r <= trigMeta_r;
			trigLast_r <= trigSync_r;
		end
	end

	// Counter saturates so a dead trigger never wraps back to OK
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			stallCnt_r <= 32'h0;
			stallCond_r <= 1'b0;
		end
		else if (trigSync_r != trigLast_r)
		begin
			stallCnt_r <= 32'h0;
			stallCond_r <= 1'b0;
		end
		else if (stallCnt_r < STALL_CYCLES)
			stallCnt_r <= stallCnt_r + 32'h1;
		else
			stallCond_r <= 1'b1;
	end

	// Command error indication, cleared only by software acknowledge
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cmdCond_r <= 1'b0;
			cause_r <= 7'h0;
		end
		else
		begin
			if (wrEn && regOfs == OFS_CMDACK && apbReq.pwdata[0])
			begin
				cmdCond_r <= 1'b0;
				cause_r <= 7'h0;
			end
			// New errors win over an acknowledge in the same cycle
			if (|cmdPulses)
			begin
				cmdCond_r <= 1'b1;
				cause_r <= cause_r | cmdPulses;
			end
		end
	end

	// Shading failure held until a good generation
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			shadeCond_r <= 1'b0;
		else if (shadeDone)
			shadeCond_r <= shadeFail;
	end

	// Sticky event status, write-one-to-clear, set wins
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			status_r <= '0;
		else if (wrEn && regOfs == OFS_CLEAR)
			status_r <= (status_r & ~apbReq.pwdata[EV_W-1:0]) | events;
		else
			status_r <= status_r | events;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			enable_r <= '0;
			ctrl_r <= CTRL_RESET;
		end
		else if (wrEn && regOfs == OFS_ENABLE)
			enable_r <= apbReq.pwdata[EV_W-1:0];
		else if (wrEn && regOfs == OFS_CTRL)
			ctrl_r <= apbReq.pwdata[0:0];
	end

	// Priority selection, smallest level first
	always_comb
	begin
		flashNxt = FLASH_SOLID;
		prioNxt = PRIO_NONE;
		if (cmdCond_r)
		begin
			flashNxt = FLASH_CMD;
			prioNxt = PRIO_CMD;
		end
		else if (shadeCond_r)
		begin
			flashNxt = FLASH_SHADE;
			prioNxt = PRIO_SHADE;
		end
		else if (lineRateExceeded || stallCond_r)
		begin
			flashNxt = FLASH_LINE;
			prioNxt = PRIO_LINE;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			flashSel_r <= FLASH_SOLID;
			prioSel_r <= PRIO_NONE;
		end
		else
		begin
			flashSel_r <= flashNxt;
			prioSel_r <= prioNxt;
		end
	end

	sled_flash_gen #(
		.ON_CYCLES(FLASH_ON),
		.OFF_CYCLES(FLASH_OFF),
		.GAP_CYCLES(FLASH_GAP)
	) flashGen (
		.clk(clk),
		.reset(reset),
		.flashCount(flashSel_r),
		.ledOn(ledRaw)
	);

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			led_r <= 1'b0;
			irq_r <= 1'b0;
			discard_r <= 1'b0;
		end
		else
		begin
			led_r <= ledRaw && ctrl_r[0];
			irq_r <= |(status_r & enable_r);
			discard_r <= discardNow;
		end
	end

	// APB read data and response
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			prdata_r <= 32'h0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r <= access;
			pslverr_r <= access && !(known(regOfs) &&
				apbReq.paddr[31:8] == 24'h0);
			prdata_r <= 32'h0;
			if (rdEn && apbReq.paddr[31:8] == 24'h0)
			begin
				case (regOfs)
					OFS_STATUS:
						prdata_r <= 32'(status_r);
					OFS_ENABLE:
						prdata_r <= 32'(enable_r);
					OFS_COND:
						prdata_r <= {20'h0, prioSel_r, 1'b0,
							flashSel_r, stallCond_r,
							lineRateExceeded, shadeCond_r,
							cmdCond_r};
					OFS_CAUSE:
						prdata_r <= 32'(cause_r);
					OFS_CTRL:
						prdata_r <= 32'(ctrl_r);
					default:
						prdata_r <= 32'h0;
				endcase
			end
		end
	end

	assign apbRsp.prdata = prdata_r;
	assign apbRsp.pready = pready_r;
	assign apbRsp.pslverr = pslverr_r;
	assign rxByteDiscard = discard_r;
	assign ledOrange = led_r;
	assign irq = irq_r;
endmodule

// >>> bench/sled_led_watch.sv
// LED watcher that counts the flashes of each pattern group
`timescale 1ns/1ps
module sled_led_watch #(
	parameter int GAP_MIN = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// LED line
	input wire logic ledOrange,
	// Flashes seen in the last complete group
	output logic [2:0] flashes
);
	logic [2:0] cnt_r;
	logic [7:0] dark_r;
	logic prev_r;
	// A dark run longer than the off time ends a group
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cnt_r <= 3'h0;
			dark_r <= 8'h00;
			prev_r <= 1'b0;
			flashes <= 3'h0;
		end
		else
		begin
			prev_r <= ledOrange;
			dark_r <= ledOrange ? 8'h00 : dark_r + 8'h01;
			if (ledOrange && !prev_r)
				cnt_r <= cnt_r + 3'h1;
			if (dark_r == 8'(GAP_MIN))
			begin
				flashes <= cnt_r;
				cnt_r <= 3'h0;
			end
		end
	end
endmodule

// >>> bench/sled_error_indicator_sva.sv
// Assertion checker for the status LED error indicator
`timescale 1ns/1ps
module sled_error_indicator_sva #(
	parameter logic [31:0] STALL_CYCLES = 32'h0000_0032
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Watched ports
	input wire sled_pkg::sled_apb_req_t apbReq,
	input wire sled_pkg::sled_apb_rsp_t apbRsp,
	input wire sled_pkg::sled_cmd_err_t cmdErr,
	input wire logic rxByteValid,
	input wire logic rxFrameOpen,
	input wire logic rxByteDiscard,
	input wire logic shadeDone,
	input wire logic shadeFail,
	input wire logic lineRateExceeded,
	input wire logic external_line_trigger,
	input wire logic ledOrange,
	input wire logic irq
);
	import sled_pkg::*;
	logic [31:0] stallCnt_r;
	logic trigPrev_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Saturates so a long quiet pin never wraps back
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			stallCnt_r <= 32'h0;
			trigPrev_r <= 1'b0;
		end
		else
		begin
			trigPrev_r <= external_line_trigger;
			if (external_line_trigger != trigPrev_r)
				stallCnt_r <= 32'h0;
			else if (stallCnt_r != 32'hFFFF_FFFF)
				stallCnt_r <= stallCnt_r + 32'h1;
		end
	end
	disc_set_a: assert property (
		rxByteValid && !rxFrameOpen |=> rxByteDiscard)
		else $error("byte outside a frame kept");
	disc_cause_a: assert property (
		rxByteDiscard |-> $past(rxByteValid) && !$past(rxFrameOpen))
		else $error("discard without a stray byte");
	cmd_dark_a: assert property (
		|cmdErr |-> ##[1:6] !ledOrange)
		else $error("command error left LED solid");
	shade_dark_a: assert property (
		shadeDone && shadeFail |-> ##[1:8] !ledOrange)
		else $error("shading failure left LED solid");
	rate_dark_a: assert property (
		$rose(lineRateExceeded) |-> ##[1:8] !ledOrange)
		else $error("line rate error left LED solid");
	stall_dark_a: assert property (
		stallCnt_r == STALL_CYCLES + 32'h4 |-> ##[0:8] !ledOrange)
		else $error("stalled trigger left LED solid");
	ready_pulse_a: assert property (apbRsp.pready |=> !apbRsp.pready)
		else $error("ready longer than one cycle");
	ready_access_a: assert property (apbRsp.pready |->
		apbReq.psel && apbReq.penable && $past(apbReq.penable))
		else $error("ready outside second access cycle");
	err_ready_a: assert property (apbRsp.pslverr |-> apbRsp.pready)
		else $error("error flag without ready");
	cover property (rxByteDiscard);
	cover property (apbRsp.pslverr);
	cover property (stallCnt_r == STALL_CYCLES + 32'h4);
endmodule
bind sled_error_indicator sled_error_indicator_sva #(
	.STALL_CYCLES(STALL_CYCLES)
) chk (
	.clk(clk), .reset(reset), .apbReq(apbReq), .apbRsp(apbRsp),
	.cmdErr(cmdErr), .rxByteValid(rxByteValid), .rxFrameOpen(rxFrameOpen),
	.rxByteDiscard(rxByteDiscard), .shadeDone(shadeDone),
	.shadeFail(shadeFail), .lineRateExceeded(lineRateExceeded),
	.external_line_trigger(external_line_trigger),
	.ledOrange(ledOrange), .irq(irq)
);

// >>> bench/tb_top.sv
// Self-checking bench for the status LED error indicator
`timescale 1ns/1ps
module tb_top;
	import sled_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	sled_apb_req_t req = '0;
	sled_apb_rsp_t rsp;
	sled_cmd_err_t cmdErr = '0;
	logic rxValid = 1'b0;
	logic rxOpen = 1'b0;
	logic shDone = 1'b0;
	logic shFail = 1'b0;
	logic rate = 1'b0;
	logic trig = 1'b0;
	logic toggleOn = 1'b1;
	logic discard, led, irq;
	logic [2:0] flashes;
	logic [31:0] d;
	logic [32:0] expQ[$];
	int errors = 0;
	int checksDone = 0;
	int seed = 27;
	always #2 clk = ~clk;
	sled_error_indicator #(.STALL_CYCLES(32'h32), .FLASH_ON(32'h4),
		.FLASH_OFF(32'h4), .FLASH_GAP(32'hC)) uut (.clk(clk),
		.reset(reset), .apbReq(req), .apbRsp(rsp), .cmdErr(cmdErr),
		.rxByteValid(rxValid), .rxFrameOpen(rxOpen),
		.rxByteDiscard(discard), .shadeDone(shDone), .shadeFail(shFail),
		.lineRateExceeded(rate), .external_line_trigger(trig),
		.ledOrange(led), .irq(irq));
	sled_led_watch #(.GAP_MIN(8)) watch (.clk(clk), .reset(reset),
		.ledOrange(led), .flashes(flashes));
	task chk(input logic [32:0] seen, input logic [32:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		if (errors == 0 && checksDone > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Reads note {pslverr, prdata}; the monitor compares at pready
	task apb(input logic [7:0] a, input logic w, input logic [31:0] v,
		input logic [32:0] e);
		@(posedge clk);
		req <= '{paddr: {24'h0, a}, psel: 1'b1, penable: 1'b0,
			pwrite: w, pwdata: v};
		if (!w)
			expQ.push_back(e);
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task pulse(input sled_cmd_err_t e);
		@(posedge clk);
		cmdErr <= e;
		@(posedge clk);
		cmdErr <= '0;
	endtask
	always @(posedge clk)
		if (rsp.pready === 1'b1 && req.pwrite === 1'b0)
			chk({rsp.pslverr, rsp.prdata}, expQ.pop_front());
	// Random trigger edges keep the stall detector quiet until stopped
	always
	begin
		repeat (3 + $unsigned($random(seed)) % 8) @(posedge clk);
		if (toggleOn)
			trig <= ~trig;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		wrap_up;
	end
	initial
	begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		apb(OFS_ENABLE, 1'b0, 32'h0, 33'h0);
		apb(OFS_CTRL, 1'b0, 32'h0, 33'h1);
		apb(OFS_COND, 1'b0, 32'h0, 33'h0);
		chk({32'h0, led}, 33'h1);
		apb(OFS_CTRL, 1'b1, 32'h0, 33'h0);
		repeat (2) @(posedge clk);
		chk({32'h0, led}, 33'h0);
		apb(OFS_CTRL, 1'b0, 32'h0, 33'h0);
		apb(OFS_CTRL, 1'b1, 32'h1, 33'h0);
		repeat (2) @(posedge clk);
		chk({32'h0, led}, 33'h1);
		d = $random(seed);
		apb(OFS_ENABLE, 1'b1, d, 33'h0);
		apb(OFS_ENABLE, 1'b0, 32'h0, {29'h0, d[3:0]});
		apb(OFS_ENABLE, 1'b1, 32'hF, 33'h0);
		for (int i = 0; i < 7; i++)
		begin
			pulse(sled_cmd_err_t'(7'h1 << i));
			apb(OFS_COND, 1'b0, 32'h0, 33'h741);
			apb(OFS_CAUSE, 1'b0, 32'h0, 33'h1 << i);
			apb(OFS_STATUS, 1'b0, 32'h0, 33'h1);
			chk({32'h0, irq}, 33'h1);
			if (i == 0)
			begin
				repeat (80) @(posedge clk);
				chk({30'h0, flashes}, 33'h4);
			end
			apb(OFS_CMDACK, 1'b1, 32'h1, 33'h0);
			apb(OFS_CLEAR, 1'b1, 32'hF, 33'h0);
			apb(OFS_COND, 1'b0, 32'h0, 33'h0);
			chk({32'h0, irq}, 33'h0);
		end
		rxOpen <= 1'b1;
		rxValid <= 1'b1;
		@(posedge clk);
		rxOpen <= 1'b0;
		@(posedge clk);
		rxValid <= 1'b0;
		chk({32'h0, discard}, 33'h0);
		@(posedge clk);
		chk({32'h0, discard}, 33'h1);
		apb(OFS_COND, 1'b0, 32'h0, 33'h741);
		apb(OFS_CAUSE, 1'b0, 32'h0, 33'h20);
		apb(OFS_CMDACK, 1'b1, 32'h1, 33'h0);
		shDone <= 1'b1;
		shFail <= 1'b1;
		@(posedge clk);
		shDone <= 1'b0;
		apb(OFS_COND, 1'b0, 32'h0, 33'h832);
		repeat (80) @(posedge clk);
		chk({30'h0, flashes}, 33'h3);
		pulse(sled_cmd_err_t'(7'h2));
		apb(OFS_COND, 1'b0, 32'h0, 33'h743);
		apb(OFS_CMDACK, 1'b1, 32'h1, 33'h0);
		rate <= 1'b1;
		apb(OFS_COND, 1'b0, 32'h0, 33'h836);
		shDone <= 1'b1;
		shFail <= 1'b0;
		@(posedge clk);
		shDone <= 1'b0;
		apb(OFS_COND, 1'b0, 32'h0, 33'h924);
		rate <= 1'b0;
		apb(OFS_COND, 1'b0, 32'h0, 33'h0);
		toggleOn <= 1'b0;
		repeat (70) @(posedge clk);
		apb(OFS_COND, 1'b0, 32'h0, 33'h928);
		toggleOn <= 1'b1;
		repeat (20) @(posedge clk);
		apb(OFS_COND, 1'b0, 32'h0, 33'h0);
		shDone <= 1'b1;
		shFail <= 1'b1;
		@(posedge clk);
		shDone <= 1'b0;
		apb(OFS_COND, 1'b0, 32'h0, 33'h832);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		apb(OFS_COND, 1'b0, 32'h0, 33'h0);
		apb(OFS_CMDACK, 1'b0, 32'h0, 33'h0);
		apb(8'h1C, 1'b0, 32'h0, {1'b1, 32'h0});
		wrap_up;
	end
endmodule
